// File: design/wcc_pkg.sv
// Package: shared widths, result codes, command kinds and carriers of the weighing command checker.
// Assumes one clock domain and a synchronous active-low reset in every user except wcc_lim_mem, which has no reset.
package wcc_pkg;

  localparam int PIDX_W = 4;
  localparam int VAL_W  = 16;
  localparam int ADDR_W = 16;
  localparam int CNT_W  = 8;
  localparam int LIM_W  = 2 * VAL_W;

  // Modbus holding-register window that maps onto the parameter table.
  localparam logic [ADDR_W-1:0] REG_BASE = 16'h0100;
  localparam logic [ADDR_W-1:0] REG_SPAN = 16'h0010;

  // Result codes, decimal value in the trailing comment.
  localparam logic [7:0] RES_OK       = 8'h00;
  localparam logic [7:0] ERR_PFAIL    = 8'h4C;  // 076
  localparam logic [7:0] ERR_MODE     = 8'h64;  // 100
  localparam logic [7:0] ERR_HIGH     = 8'h65;  // 101
  localparam logic [7:0] ERR_LOW      = 8'h66;  // 102
  localparam logic [7:0] ERR_ADDR     = 8'h67;  // 103
  localparam logic [7:0] ERR_COUNT    = 8'h68;  // 104
  localparam logic [7:0] ERR_DATA     = 8'h69;  // 105
  localparam logic [7:0] ERR_PENDING  = 8'h6A;  // 106
  localparam logic [7:0] ERR_MOTION   = 8'h6E;  // 110
  localparam logic [7:0] ERR_NEGGROSS = 8'h6F;  // 111
  localparam logic [7:0] ERR_NETMODE  = 8'h70;  // 112

  localparam logic SRC_PANEL = 1'b0;
  localparam logic SRC_COMM  = 1'b1;

  typedef enum logic [2:0] {
    KIND_ZERO,
    KIND_TARE,
    KIND_PRINT,
    KIND_WRITE,
    KIND_PARAM
  } wcc_kind_e;

  typedef struct packed {
    logic                    src;
    wcc_kind_e               kind;
    logic [PIDX_W-1:0]       idx;
    logic signed [VAL_W-1:0] value;
    logic [ADDR_W-1:0]       startAddr;
    logic [CNT_W-1:0]        regCount;
    logic                    dataOk;
  } wcc_req_s;

  typedef struct packed {
    logic powerLow;
    logic stable;
    logic motionCheck;
    logic unipolar;
    logic grossNeg;
    logic netMode;
    logic modeOk;
  } wcc_stat_s;

endpackage

// File: design/wcc_lim_mem.sv
// Limit table: one word per parameter, minimum in the upper half, maximum in the lower.
// Assumes the loader and the reader share clk; read data appear one edge after the address.
`timescale 1ns/1ps
`default_nettype none
module wcc_lim_mem
  import wcc_pkg::*;
#(
  parameter int AW = PIDX_W,
  parameter int DW = LIM_W
) (
  input  wire logic          clk,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [DW-1:0] wrData,
  input  wire logic [AW-1:0] rdAddr,
  output logic      [DW-1:0] rdData
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule // wcc_lim_mem
`default_nettype wire

// File: design/wcc_checker.sv
// Command checker: validates panel and Modbus requests and answers with a result code.
// Assumes a command executor that raises execDone when an accepted command has finished.
`timescale 1ns/1ps
`default_nettype none
module wcc_checker
  import wcc_pkg::*;
#(
  parameter int NPARAM   = 16,
  parameter int MAX_REGS = 8
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              reqValid,
  input  wire wcc_req_s          req,
  input  wire wcc_stat_s         stat,
  input  wire logic              execDone,
  input  wire logic              limWr,
  input  wire logic [PIDX_W-1:0] limAddr,
  input  wire logic [LIM_W-1:0]  limData,
  output logic                   reqReady,
  output logic                   respValid,
  output logic                   respSrc,
  output logic [7:0]             respCode,
  output logic                   execStart,
  output wcc_kind_e              execKind,
  output logic                   paramWrEn,
  output logic [PIDX_W-1:0]      paramIdx,
  output logic signed [VAL_W-1:0] paramVal,
  output logic                   pending,
  output logic                   powerFail,
  output logic                   weightValid
);

  typedef enum logic [1:0] {ST_IDLE, ST_CHECK} wcc_state_e;

  function automatic logic [PIDX_W-1:0] regIndex(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - REG_BASE;
    return d[PIDX_W-1:0];
  endfunction

  wcc_state_e           state_r, state_nxt;
  wcc_req_s             cur_r, cur_nxt;
  logic                 ready_r, ready_nxt;
  logic                 respValid_r, respValid_nxt;
  logic                 respSrc_r, respSrc_nxt;
  logic [7:0]           respCode_r, respCode_nxt;
  logic                 execStart_r, execStart_nxt;
  wcc_kind_e            execKind_r, execKind_nxt;
  logic                 paramWrEn_r, paramWrEn_nxt;
  logic [PIDX_W-1:0]    paramIdx_r, paramIdx_nxt;
  logic signed [VAL_W-1:0] paramVal_r, paramVal_nxt;
  logic                 pending_r, pending_nxt;
  logic                 powerFail_r, powerFail_nxt;
  logic                 weightValid_r, weightValid_nxt;

  logic [PIDX_W-1:0]    rdAddr;
  logic [LIM_W-1:0]     limWord;
  logic signed [VAL_W-1:0] limMin, limMax;
  logic [ADDR_W:0]      endAddr;
  logic                 addrBad, countBad, pendBlock;
  logic [7:0]           verdict;

  ////////////////////////////////////////////////////////////////////////////
  // Limit lookup, addressed while the request is taken.

  always_comb begin
    rdAddr = (req.kind == KIND_WRITE) ? regIndex(req.startAddr) : req.idx;
  end

  wcc_lim_mem #(.AW(PIDX_W), .DW(LIM_W)) u_lim (
    .clk    (clk),
    .wrEn   (limWr),
    .wrAddr (limAddr),
    .wrData (limData),
    .rdAddr (rdAddr),
    .rdData (limWord)
  );

  assign limMin = limWord[LIM_W-1:VAL_W];
  assign limMax = limWord[VAL_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, first failing check wins.

  always_comb begin
    endAddr   = {1'b0, cur_r.startAddr} + {{(ADDR_W-CNT_W+1){1'b0}}, cur_r.regCount};
    addrBad   = (cur_r.startAddr < REG_BASE)
             || (cur_r.startAddr >= REG_BASE + REG_SPAN);
    countBad  = (cur_r.regCount == 8'h00)
             || (cur_r.regCount > CNT_W'(MAX_REGS))
             || (endAddr > {1'b0, REG_BASE + REG_SPAN});
    pendBlock = pending_r;
    verdict   = RES_OK;
    if (stat.powerLow) begin
      verdict = ERR_PFAIL;
    end else if (pendBlock) begin
      verdict = (cur_r.src == SRC_COMM) ? ERR_PENDING : ERR_MODE;
    end else if (!stat.modeOk) begin
      verdict = ERR_MODE;
    end else begin
      case (cur_r.kind)
        KIND_ZERO: begin
          if (!stat.stable) verdict = ERR_MOTION;
          else if (stat.netMode) verdict = ERR_NETMODE;
        end
        KIND_TARE: begin
          if (stat.motionCheck && !stat.stable) verdict = ERR_MOTION;
          else if (stat.unipolar && stat.grossNeg) verdict = ERR_NEGGROSS;
        end
        KIND_PRINT: begin
          if (stat.motionCheck && !stat.stable) verdict = ERR_MOTION;
        end
        KIND_WRITE: begin
          if (addrBad) verdict = ERR_ADDR;
          else if (countBad) verdict = ERR_COUNT;
          else if (!cur_r.dataOk) verdict = ERR_DATA;
          else if (cur_r.value > limMax) verdict = ERR_HIGH;
          else if (cur_r.value < limMin) verdict = ERR_LOW;
        end
        KIND_PARAM: begin
          if (!cur_r.dataOk) verdict = ERR_DATA;
          else if (cur_r.value > limMax) verdict = ERR_HIGH;
          else if (cur_r.value < limMin) verdict = ERR_LOW;
        end
        default: verdict = ERR_MODE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing and outputs.

  always_comb begin
    state_nxt       = state_r;
    cur_nxt         = cur_r;
    ready_nxt       = ready_r;
    respValid_nxt   = 1'b0;
    respSrc_nxt     = respSrc_r;
    respCode_nxt    = respCode_r;
    execStart_nxt   = 1'b0;
    execKind_nxt    = execKind_r;
    paramWrEn_nxt   = 1'b0;
    paramIdx_nxt    = paramIdx_r;
    paramVal_nxt    = paramVal_r;
    pending_nxt     = pending_r;
    powerFail_nxt   = stat.powerLow;
    weightValid_nxt = !stat.powerLow;
    if (execDone) begin
      pending_nxt = 1'b0;
    end
    case (state_r)
      ST_IDLE: begin
        if (reqValid && ready_r) begin
          cur_nxt   = req;
          ready_nxt = 1'b0;
          state_nxt = ST_CHECK;
        end
      end
      ST_CHECK: begin
        respValid_nxt = 1'b1;
        respSrc_nxt   = cur_r.src;
        respCode_nxt  = verdict;
        ready_nxt     = 1'b1;
        state_nxt     = ST_IDLE;
        if (verdict == RES_OK) begin
          execStart_nxt = 1'b1;
          execKind_nxt  = cur_r.kind;
          pending_nxt   = 1'b1;
          if (cur_r.kind == KIND_WRITE || cur_r.kind == KIND_PARAM) begin
            paramWrEn_nxt = 1'b1;
            paramIdx_nxt  = (cur_r.kind == KIND_WRITE) ? regIndex(cur_r.startAddr) : cur_r.idx;
            paramVal_nxt  = cur_r.value;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        ready_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r       <= ST_IDLE;
      cur_r         <= '0;
      ready_r       <= 1'b1;
      respValid_r   <= 1'b0;
      respSrc_r     <= SRC_PANEL;
      respCode_r    <= RES_OK;
      execStart_r   <= 1'b0;
      execKind_r    <= KIND_ZERO;
      paramWrEn_r   <= 1'b0;
      paramIdx_r    <= '0;
      paramVal_r    <= '0;
      pending_r     <= 1'b0;
      powerFail_r   <= 1'b0;
      weightValid_r <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      cur_r         <= cur_nxt;
      ready_r       <= ready_nxt;
      respValid_r   <= respValid_nxt;
      respSrc_r     <= respSrc_nxt;
      respCode_r    <= respCode_nxt;
      execStart_r   <= execStart_nxt;
      execKind_r    <= execKind_nxt;
      paramWrEn_r   <= paramWrEn_nxt;
      paramIdx_r    <= paramIdx_nxt;
      paramVal_r    <= paramVal_nxt;
      pending_r     <= pending_nxt;
      powerFail_r   <= powerFail_nxt;
      weightValid_r <= weightValid_nxt;
    end
  end

  assign reqReady    = ready_r;
  assign respValid   = respValid_r;
  assign respSrc     = respSrc_r;
  assign respCode    = respCode_r;
  assign execStart   = execStart_r;
  assign execKind    = execKind_r;
  assign paramWrEn   = paramWrEn_r;
  assign paramIdx    = paramIdx_r;
  assign paramVal    = paramVal_r;
  assign pending     = pending_r;
  assign powerFail   = powerFail_r;
  assign weightValid = weightValid_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic inCheck;
  assign inCheck = (state_r == ST_CHECK);

  property p_pfail_code;
    @(posedge clk) disable iff (!nrst)
      inCheck && stat.powerLow |=> respValid_r && respCode_r == ERR_PFAIL;
  endproperty
  a_pfail_code: assert property (p_pfail_code) else $error("power fail not reported");

  property p_pfail_weight;
    @(posedge clk) disable iff (!nrst)
      stat.powerLow |=> powerFail_r && !weightValid_r;
  endproperty
  a_pfail_weight: assert property (p_pfail_weight) else $error("weight valid in power fail");

  property p_mode;
    @(posedge clk) disable iff (!nrst)
      inCheck && !stat.powerLow && !pending_r && !stat.modeOk |=> respCode_r == ERR_MODE;
  endproperty
  a_mode: assert property (p_mode) else $error("wrong mode not rejected");

  property p_pending;
    @(posedge clk) disable iff (!nrst)
      inCheck && !stat.powerLow && pending_r && cur_r.src == SRC_COMM
      |=> respCode_r == ERR_PENDING;
  endproperty
  a_pending: assert property (p_pending) else $error("pending not reported");

  property p_panel_no106;
    @(posedge clk) disable iff (!nrst)
      respValid_r && respSrc_r == SRC_PANEL |-> respCode_r != ERR_PENDING;
  endproperty
  a_panel_no106: assert property (p_panel_no106) else $error("106 sent to panel");

  property p_zero_stable;
    @(posedge clk) disable iff (!nrst)
      inCheck && !stat.powerLow && !pending_r && stat.modeOk
      && cur_r.kind == KIND_ZERO && !stat.stable |=> respCode_r == ERR_MOTION;
  endproperty
  a_zero_stable: assert property (p_zero_stable) else $error("unstable zero accepted");

  property p_zero_net;
    @(posedge clk) disable iff (!nrst)
      inCheck && !stat.powerLow && !pending_r && stat.modeOk
      && cur_r.kind == KIND_ZERO && stat.stable && stat.netMode |=> respCode_r == ERR_NETMODE;
  endproperty
  a_zero_net: assert property (p_zero_net) else $error("zero in net mode accepted");

  property p_tare_neg;
    @(posedge clk) disable iff (!nrst)
      inCheck && !stat.powerLow && !pending_r && stat.modeOk && cur_r.kind == KIND_TARE
      && !(stat.motionCheck && !stat.stable) && stat.unipolar && stat.grossNeg
      |=> respCode_r == ERR_NEGGROSS;
  endproperty
  a_tare_neg: assert property (p_tare_neg) else $error("negative gross tare accepted");

  property p_write_addr;
    @(posedge clk) disable iff (!nrst)
      inCheck && !stat.powerLow && !pending_r && stat.modeOk
      && cur_r.kind == KIND_WRITE && addrBad |=> respCode_r == ERR_ADDR;
  endproperty
  a_write_addr: assert property (p_write_addr) else $error("bad start address accepted");

  property p_reject_quiet;
    @(posedge clk) disable iff (!nrst)
      respValid_r && respCode_r != RES_OK |-> !execStart_r && !paramWrEn_r && $stable(paramVal_r);
  endproperty
  a_reject_quiet: assert property (p_reject_quiet) else $error("rejected command took effect");

  property p_answer_time;
    @(posedge clk) disable iff (!nrst)
      reqValid && reqReady |=> !respValid_r ##1 respValid_r ##1 !respValid_r;
  endproperty
  a_answer_time: assert property (p_answer_time) else $error("answer not two cycles after request");

  c_accept:  cover property (@(posedge clk) respValid_r && respCode_r == RES_OK);
  c_pending: cover property (@(posedge clk) respValid_r && respCode_r == ERR_PENDING);
  c_high:    cover property (@(posedge clk) respValid_r && respCode_r == ERR_HIGH);
  c_motion:  cover property (@(posedge clk) respValid_r && respCode_r == ERR_MOTION);

endmodule // wcc_checker
`default_nettype wire

// File: sim/wcc_exec_model.sv
// Executor model: answers every accepted command with a one-cycle done pulse.
// Assumes the checker's clk and nrst; the done pulse comes delay+2 cycles after execStart.
`timescale 1ns/1ps
`default_nettype none
module wcc_exec_model
  import wcc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       execStart,
  input  wire logic [7:0] delay,
  output logic            execDone
);
  logic [7:0] cnt_r;
  logic       busy_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_r    <= 8'h00;
      busy_r   <= 1'b0;
      execDone <= 1'b0;
    end else begin
      execDone <= 1'b0;
      if (execStart) begin
        busy_r <= 1'b1;
        cnt_r  <= 8'h00;
      end else if (busy_r && cnt_r == delay) begin
        busy_r   <= 1'b0;
        execDone <= 1'b1;
      end else if (busy_r) begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
endmodule // wcc_exec_model
`default_nettype wire

// File: sim/tb_top.sv
// Testbench: table of requests with the result codes they should give, then hand tests.
// Assumes wcc_checker and the executor model; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import wcc_pkg::*;
;
  typedef struct packed {
    wcc_req_s  req;
    wcc_stat_s st;
    logic [7:0] code;
  } wcc_tb_row_s;

  logic                    clk;
  logic                    nrst;
  logic                    reqValid;
  wcc_req_s                req;
  wcc_stat_s               stat;
  logic                    execDone;
  logic                    limWr;
  logic [PIDX_W-1:0]       limAddr;
  logic [LIM_W-1:0]        limData;
  logic                    reqReady;
  logic                    respValid;
  logic                    respSrc;
  logic [7:0]              respCode;
  logic                    execStart;
  wcc_kind_e               execKind;
  logic                    paramWrEn;
  logic [PIDX_W-1:0]       paramIdx;
  logic signed [VAL_W-1:0] paramVal;
  logic                    pending;
  logic                    powerFail;
  logic                    weightValid;
  logic [7:0]              execDelay;
  logic signed [VAL_W-1:0] lastVal;
  int                      errors;
  int                      cmp_count;
  int                      cycles;
  wcc_tb_row_s             rows[$];

  wcc_checker uut (.clk(clk), .nrst(nrst), .reqValid(reqValid), .req(req), .stat(stat),
    .execDone(execDone), .limWr(limWr), .limAddr(limAddr), .limData(limData),
    .reqReady(reqReady), .respValid(respValid), .respSrc(respSrc), .respCode(respCode),
    .execStart(execStart), .execKind(execKind), .paramWrEn(paramWrEn), .paramIdx(paramIdx),
    .paramVal(paramVal), .pending(pending), .powerFail(powerFail), .weightValid(weightValid));

  wcc_exec_model u_exec (.clk(clk), .nrst(nrst), .execStart(execStart), .delay(execDelay),
    .execDone(execDone));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task results;
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic wcc_tb_row_s mk(input logic s, input wcc_kind_e k, input logic [3:0] i,
    input logic signed [15:0] v, input logic [15:0] a, input logic [7:0] n, input logic ok,
    input wcc_stat_s st, input logic [7:0] code);
    mk = '{req: '{s, k, i, v, a, n, ok}, st: st, code: code};
  endfunction

  task automatic send(input wcc_tb_row_s r);
    logic        ok;
    logic        wr;
    logic [15:0] d;
    ok = (r.code == RES_OK);
    wr = ok && (r.req.kind == KIND_WRITE || r.req.kind == KIND_PARAM);
    d  = r.req.startAddr - REG_BASE;
    @(negedge clk);
    req      = r.req;
    stat     = r.st;
    reqValid = 1'b1;
    @(negedge clk);
    reqValid = 1'b0;
    check("reqReady", reqReady, 1'b0);
    @(negedge clk);
    check("respValid", respValid, 1'b1);
    check("respCode", respCode, r.code);
    check("respSrc", respSrc, r.req.src);
    check("execStart", execStart, ok);
    check("paramWrEn", paramWrEn, wr);
    if (wr) begin
      check("paramIdx", paramIdx, (r.req.kind == KIND_WRITE) ? d[3:0] : r.req.idx);
      check("paramVal", paramVal, r.req.value);
      lastVal = r.req.value;
    end else begin
      check("paramVal", paramVal, lastVal);
    end
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (pending !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("pending", pending, 1'b0);
  endtask

  task automatic lim(input logic [3:0] a, input logic [15:0] mn, input logic [15:0] mx);
    @(negedge clk);
    limWr   = 1'b1;
    limAddr = a;
    limData = {mn, mx};
    @(negedge clk);
    limWr = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end

  initial begin
    nrst = 1'b0; reqValid = 1'b0; req = '0; stat = 7'h21; limWr = 1'b0;
    limAddr = 4'h0; limData = 32'h0; execDelay = 8'h03; lastVal = 16'h0;
    errors = 0; cmp_count = 0; cycles = 0;
    rows.push_back(mk(1'b1, KIND_WRITE, 4'h0, 16'h0064, 16'h0100, 8'h08, 1'b1, 7'h21, RES_OK));
    rows.push_back(mk(1'b1, KIND_ZERO, 4'h0, 16'h0, 16'h0, 8'h0, 1'b1, 7'h61, ERR_PFAIL));
    rows.push_back(mk(1'b1, KIND_ZERO, 4'h0, 16'h0, 16'h0, 8'h0, 1'b1, 7'h20, ERR_MODE));
    rows.push_back(mk(1'b1, KIND_ZERO, 4'h0, 16'h0, 16'h0, 8'h0, 1'b1, 7'h01, ERR_MOTION));
    rows.push_back(mk(1'b0, KIND_ZERO, 4'h0, 16'h0, 16'h0, 8'h0, 1'b1, 7'h23, ERR_NETMODE));
    rows.push_back(mk(1'b1, KIND_ZERO, 4'h0, 16'h0, 16'h0, 8'h0, 1'b1, 7'h21, RES_OK));
    rows.push_back(mk(1'b1, KIND_TARE, 4'h0, 16'h0, 16'h0, 8'h0, 1'b1, 7'h11, ERR_MOTION));
    rows.push_back(mk(1'b1, KIND_TARE, 4'h0, 16'h0, 16'h0, 8'h0, 1'b1, 7'h0D, ERR_NEGGROSS));
    rows.push_back(mk(1'b0, KIND_TARE, 4'h0, 16'h0, 16'h0, 8'h0, 1'b1, 7'h01, RES_OK));
    rows.push_back(mk(1'b1, KIND_PRINT, 4'h0, 16'h0, 16'h0, 8'h0, 1'b1, 7'h11, ERR_MOTION));
    rows.push_back(mk(1'b1, KIND_PRINT, 4'h0, 16'h0, 16'h0, 8'h0, 1'b1, 7'h01, RES_OK));
    rows.push_back(mk(1'b1, KIND_WRITE, 4'h0, 16'h0001, 16'h00FF, 8'h01, 1'b1, 7'h21, ERR_ADDR));
    rows.push_back(mk(1'b1, KIND_WRITE, 4'h0, 16'h0001, 16'h0110, 8'h01, 1'b1, 7'h21, ERR_ADDR));
    rows.push_back(mk(1'b1, KIND_WRITE, 4'h0, 16'h0001, 16'h0100, 8'h00, 1'b1, 7'h21, ERR_COUNT));
    rows.push_back(mk(1'b1, KIND_WRITE, 4'h0, 16'h0001, 16'h0100, 8'h09, 1'b1, 7'h21, ERR_COUNT));
    rows.push_back(mk(1'b1, KIND_WRITE, 4'h0, 16'h0001, 16'h010F, 8'h02, 1'b1, 7'h21, ERR_COUNT));
    rows.push_back(mk(1'b1, KIND_WRITE, 4'h0, 16'h0001, 16'h0100, 8'h01, 1'b0, 7'h21, ERR_DATA));
    rows.push_back(mk(1'b1, KIND_WRITE, 4'h0, 16'h0065, 16'h0100, 8'h01, 1'b1, 7'h21, ERR_HIGH));
    rows.push_back(mk(1'b1, KIND_WRITE, 4'h0, 16'hFFF5, 16'h0100, 8'h01, 1'b1, 7'h21, ERR_LOW));
    rows.push_back(mk(1'b1, KIND_WRITE, 4'h0, 16'h0033, 16'h0103, 8'h01, 1'b1, 7'h21, ERR_HIGH));
    rows.push_back(mk(1'b1, KIND_WRITE, 4'h0, 16'h0032, 16'h010F, 8'h01, 1'b1, 7'h21, RES_OK));
    rows.push_back(mk(1'b0, KIND_PARAM, 4'h3, 16'h0000, 16'h0, 8'h0, 1'b1, 7'h21, RES_OK));
    rows.push_back(mk(1'b0, KIND_PARAM, 4'h0, 16'hFFF6, 16'h0, 8'h0, 1'b1, 7'h21, RES_OK));
    rows.push_back(mk(1'b0, KIND_PARAM, 4'h0, 16'h0001, 16'h0, 8'h0, 1'b0, 7'h21, ERR_DATA));
    repeat (10) @(negedge clk);
    check("reqReady", reqReady, 1'b1);
    check("respValid", respValid, 1'b0);
    check("respCode", respCode, RES_OK);
    check("pending", pending, 1'b0);
    check("powerFail", powerFail, 1'b0);
    nrst = 1'b1;
    lim(4'h0, 16'hFFF6, 16'h0064);
    lim(4'h3, 16'h0000, 16'h0032);
    lim(4'hF, 16'h0000, 16'h0032);
    foreach (rows[i]) begin
      send(rows[i]);
      wait_idle();
    end
    // Power fail shows one cycle after the supply flag and clears with it.
    stat = 7'h61;
    repeat (2) @(negedge clk);
    check("powerFail", powerFail, 1'b1);
    check("weightValid", weightValid, 1'b0);
    stat = 7'h21;
    repeat (2) @(negedge clk);
    check("weightValid", weightValid, 1'b1);
    // A slow executor keeps the first command pending while two more arrive.
    execDelay = 8'h28;
    send(mk(1'b1, KIND_ZERO, 4'h0, 16'h0, 16'h0, 8'h0, 1'b1, 7'h21, RES_OK));
    send(mk(1'b1, KIND_TARE, 4'h0, 16'h0, 16'h0, 8'h0, 1'b1, 7'h21, ERR_PENDING));
    send(mk(1'b0, KIND_TARE, 4'h0, 16'h0, 16'h0, 8'h0, 1'b1, 7'h21, ERR_MODE));
    check("pending", pending, 1'b1);
    wait_idle();
    send(mk(1'b1, KIND_TARE, 4'h0, 16'h0, 16'h0, 8'h0, 1'b1, 7'h21, RES_OK));
    wait_idle();
    results();
  end
endmodule // tb_top
`default_nettype wire
